// File: tcr_timers.sv
// tcr_timers: four timers, rate generators and clock routing
// assumes pins arrive asynchronously and software uses the reg port
`timescale 1ns/1ps
module tcr_timers #(
    parameter int N_TMR = 4,
    parameter int N_RGN = 8,
    parameter int N_CLK = 10,
    parameter int N_CTRL = 4,
    parameter int TW = 16
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [tcr_pkg::TCR_AW-1:0] reg_addr,
    input wire logic [tcr_pkg::TCR_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tcr_pkg::TCR_DW-1:0] reg_rdata,
    // timer pins
    input wire logic [N_TMR-1:0] timer_in_pin,
    input wire logic gate_in_a,
    input wire logic gate_in_b,
    output logic [N_TMR-1:0] timer_out_pin,
    // clock pins and routed clocks
    input wire logic [N_CLK-1:0] ext_clock_in,
    input wire logic dedicated_timer_clock_pin,
    output logic [N_RGN-1:0] baud_rate_gen_out,
    output logic [N_CTRL-1:0] bank_clk_out,
    output logic unit_timer_tick
);
    import tcr_pkg::*;

    // positions inside the synchroniser vector
    localparam int NS = N_TMR + 2 + N_CLK + 1;
    localparam int GA = N_TMR;
    localparam int GB = N_TMR + 1;
    localparam int CB = N_TMR + 2;
    localparam int TM = NS - 1;
    localparam int IX5 = CB + TCR_EXT5_IX;
    localparam int NB = N_CLK + N_RGN;

    // register address match
    function automatic logic dec(input logic [TCR_AW-1:0] a,
                                 input logic [TCR_AW-1:0] base,
                                 input int i);
        dec = (a == base + TCR_AW'(i * TCR_STRIDE));
    endfunction

    // synchroniser stages and filtered pin levels
    logic [NS-1:0] pins;
    logic [NS-1:0] s1_r, s2_r, s3_r;
    logic [NS-1:0] flt_r, flt_d_r, flt_nxt;
    logic [NS-1:0] rise, fall;
    // configuration registers
    logic [TCR_MODE_W-1:0] mode_r [N_TMR];
    logic [TW-1:0] ref_r [N_TMR];
    logic [TCR_ROUTE_W-1:0] route_r;
    logic [TCR_DW-1:0] bsel_r;
    logic [TW-1:0] div_r [N_RGN];
    // timer state
    logic [TW-1:0] cnt_r [N_TMR];
    logic [TW-1:0] cnt_nxt [N_TMR];
    logic [N_TMR-1:0] hit, hit_r, out_r, out_nxt;
    logic [TCR_PRE_W-1:0] pre_r;
    logic pre_tick;
    // rate generators and routing
    logic [TW-1:0] bcnt_r [N_RGN];
    logic [TW-1:0] bcnt_nxt [N_RGN];
    logic [N_RGN-1:0] rgn_src, rgn_ev, rgn_r;
    logic [NB-1:0] bank_src;
    logic [N_CTRL-1:0] bank_r, bank_nxt;
    logic ext5_sel, dclk_sel, rate_gen1_out, unit_r, unit_nxt;
    logic [TCR_DW-1:0] rd_val, rdata_r;

    // all pins into one vector
    assign pins = {dedicated_timer_clock_pin, ext_clock_in,
                   gate_in_b, gate_in_a, timer_in_pin};
    // take new level once stages two and three agree
    assign flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
    assign rise = flt_r & ~flt_d_r;
    assign fall = ~flt_r & flt_d_r;

    // three-stage synchroniser with agreement filter
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            flt_r <= '0;
            flt_d_r <= '0;
        end else if (clk_en) begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= flt_nxt;
            flt_d_r <= flt_r;
        end
    end

    // free-running divide-by-16 prescaler
    assign pre_tick = (pre_r == TCR_PRE_W'(TCR_DIV16 - 1));
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= '0;
        end else if (clk_en) begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // software-writable configuration
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < N_TMR; i++) begin
                mode_r[i] <= TCR_MODE_RST;
                ref_r[i] <= TW'(TCR_REF_RST);
            end
            for (int j = 0; j < N_RGN; j++) begin
                div_r[j] <= TW'(TCR_RGN_RST);
            end
            route_r <= TCR_ROUTE_RST;
            bsel_r <= TCR_BSEL_RST;
        end else if (clk_en && reg_wr) begin
            for (int i = 0; i < N_TMR; i++) begin
                if (dec(reg_addr, TCR_MODE_BASE, i)) begin
                    mode_r[i] <= reg_wdata[TCR_MODE_W-1:0];
                end
                if (dec(reg_addr, TCR_REF_BASE, i)) begin
                    ref_r[i] <= reg_wdata[TW-1:0];
                end
            end
            for (int j = 0; j < N_RGN; j++) begin
                if (dec(reg_addr, TCR_RGN_BASE, j)) begin
                    div_r[j] <= reg_wdata[TW-1:0];
                end
            end
            if (reg_addr == TCR_ROUTE_ADDR) begin
                route_r <= reg_wdata[TCR_ROUTE_W-1:0];
            end
            if (reg_addr == TCR_BSEL_ADDR) begin
                bsel_r <= reg_wdata;
            end
        end
    end

    // per-timer clock select, gate and compare
    for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
        // first half on gate a, second half on gate b
        localparam int GI = (i < N_TMR / 2) ? GA : GB;
        localparam int PV = (i + N_TMR - 1) % N_TMR;
        logic [1:0] src, edg;
        logic en, tog, gen, pin_ev, src_ev, gate_ok, rst_cnt, tick;
        assign src = mode_r[i][TCR_F_SRC +: 2];
        assign edg = mode_r[i][TCR_F_EDGE +: 2];
        assign tog = mode_r[i][TCR_F_TOG];
        assign gen = mode_r[i][TCR_F_GATE];
        assign en = mode_r[i][TCR_F_EN];
        // chosen capture edges of the input pin
        assign pin_ev = (edg[TCR_E_RISE] & rise[i])
                      | (edg[TCR_E_FALL] & fall[i]);
        // source mux; cascade takes previous timer's event
        assign src_ev = (src == TCR_SRC_CASC) ? hit_r[PV]
                      : (src == TCR_SRC_SYS) ? 1'b1
                      : (src == TCR_SRC_DIV) ? pre_tick
                      : pin_ev;
        // gate low lets it count, gate falling edge restarts
        assign gate_ok = !gen || !flt_r[GI];
        assign rst_cnt = !en || (gen && fall[GI]);
        assign tick = en && gate_ok && src_ev;
        assign hit[i] = tick && (cnt_r[i] == ref_r[i]);
        // count wraps to zero on the reference value
        assign cnt_nxt[i] = (rst_cnt || hit[i]) ? '0
                          : tick ? cnt_r[i] + 1'b1 : cnt_r[i];
        // low pulse, or invert the present level
        assign out_nxt[i] = tog ? (out_r[i] ^ hit[i])
                                : !hit[i];

        property p_pulse;
            @(posedge ref_clk) disable iff (!rst_b || !clk_en)
            hit[i] && !tog |=> !timer_out_pin[i];
        endproperty
        a_pulse: assert property (p_pulse)
            else $error("pulse mode output not low after match");

        property p_toggle;
            @(posedge ref_clk) disable iff (!rst_b || !clk_en)
            hit[i] && tog |=> timer_out_pin[i] != $past(timer_out_pin[i]);
        endproperty
        a_toggle: assert property (p_toggle)
            else $error("toggle mode output did not invert");

        property p_wrap;
            @(posedge ref_clk) disable iff (!rst_b || !clk_en)
            hit[i] |=> cnt_r[i] == '0;
        endproperty
        a_wrap: assert property (p_wrap)
            else $error("counter not cleared after match");

        property p_gate;
            @(posedge ref_clk) disable iff (!rst_b || !clk_en)
            en && gen && flt_r[GI] |=> $stable(cnt_r[i]);
        endproperty
        a_gate: assert property (p_gate)
            else $error("counter moved while gate high");

        property p_edge;
            @(posedge ref_clk) disable iff (!rst_b || !clk_en)
            src == TCR_SRC_PIN && edg == 2'h1 && fall[i] |-> !tick;
        endproperty
        a_edge: assert property (p_edge)
            else $error("rise-only capture counted a fall");

        property p_casc;
            @(posedge ref_clk) disable iff (!rst_b || !clk_en)
            src == TCR_SRC_CASC && en && gate_ok && hit_r[PV]
                && !hit[i] && !rst_cnt
                |=> cnt_r[i] == TW'($past(cnt_r[i]) + 1'b1);
        endproperty
        a_casc: assert property (p_casc)
            else $error("cascaded timer missed carry");

        c_casc: cover property (@(posedge ref_clk)
            src == TCR_SRC_CASC && hit[i]);
        c_pulse: cover property (@(posedge ref_clk) hit[i] && !tog);
    end

    // timer counters, outputs and carry registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < N_TMR; i++) begin
                cnt_r[i] <= '0;
            end
            hit_r <= '0;
            out_r <= '1;
        end else if (clk_en) begin
            for (int i = 0; i < N_TMR; i++) begin
                cnt_r[i] <= cnt_nxt[i];
            end
            hit_r <= hit;
            out_r <= out_nxt;
        end
    end

    // routing controls
    assign ext5_sel = route_r[TCR_F_EXT5];
    assign dclk_sel = route_r[TCR_F_DCLK];

    // rate generators: toggle when count meets divisor
    for (genvar j = 0; j < N_RGN; j++) begin : g_rgn
        if (j == 0) begin : g_first
            // fifth clock pin when selected, else internal
            assign rgn_src[j] = ext5_sel ? rise[IX5] : 1'b1;
        end else begin : g_rest
            assign rgn_src[j] = 1'b1;
        end
        assign rgn_ev[j] = rgn_src[j] && (bcnt_r[j] == div_r[j]);
        assign bcnt_nxt[j] = rgn_ev[j] ? '0
                           : rgn_src[j] ? bcnt_r[j] + 1'b1 : bcnt_r[j];
    end

    // rate generator state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int j = 0; j < N_RGN; j++) begin
                bcnt_r[j] <= '0;
            end
            rgn_r <= '0;
        end else if (clk_en) begin
            for (int j = 0; j < N_RGN; j++) begin
                bcnt_r[j] <= bcnt_nxt[j];
            end
            rgn_r <= rgn_r ^ rgn_ev;
        end
    end

    // bank selector: codes below N_CLK pick pins, then generators
    assign bank_src = {rgn_r, flt_r[CB +: N_CLK]};
    for (genvar k = 0; k < N_CTRL; k++) begin : g_bank
        logic [TCR_BSEL_W-1:0] sel;
        assign sel = bsel_r[k * TCR_BSEL_W +: TCR_BSEL_W];
        assign bank_nxt[k] = (int'(sel) < NB) ? bank_src[sel]
                                              : 1'b0;
    end

    // unit timer tick: dedicated pin overrides the generator
    assign rate_gen1_out = rgn_r[0];
    assign unit_nxt = dclk_sel ? rise[TM]
                    : (rgn_ev[0] && !rate_gen1_out);

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_val = '0;
        for (int i = 0; i < N_TMR; i++) begin
            if (dec(reg_addr, TCR_MODE_BASE, i)) begin
                rd_val = TCR_DW'(mode_r[i]);
            end
            if (dec(reg_addr, TCR_REF_BASE, i)) begin
                rd_val = TCR_DW'(ref_r[i]);
            end
            if (dec(reg_addr, TCR_CNT_BASE, i)) begin
                rd_val = TCR_DW'(cnt_r[i]);
            end
        end
        for (int j = 0; j < N_RGN; j++) begin
            if (dec(reg_addr, TCR_RGN_BASE, j)) begin
                rd_val = TCR_DW'(div_r[j]);
            end
        end
        if (reg_addr == TCR_ROUTE_ADDR) begin
            rd_val = TCR_DW'(route_r);
        end
        if (reg_addr == TCR_BSEL_ADDR) begin
            rd_val = bsel_r;
        end
    end

    // registered outputs: routing and read data
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_r <= '0;
            unit_r <= 1'b0;
            rdata_r <= '0;
        end else if (clk_en) begin
            bank_r <= bank_nxt;
            unit_r <= unit_nxt;
            rdata_r <= reg_rd ? rd_val : '0;
        end
    end

    assign reg_rdata = rdata_r;
    assign timer_out_pin = out_r;
    assign baud_rate_gen_out = rgn_r;
    assign bank_clk_out = bank_r;
    assign unit_timer_tick = unit_r;

    property p_div16;
        @(posedge ref_clk) disable iff (!rst_b || !clk_en)
        pre_tick |=> !pre_tick [*8];
    endproperty
    a_div16: assert property (p_div16)
        else $error("prescaler tick came too early");

    property p_dclk;
        @(posedge ref_clk) disable iff (!rst_b || !clk_en)
        dclk_sel && !rise[TM] |=> !unit_timer_tick;
    endproperty
    a_dclk: assert property (p_dclk)
        else $error("generator reached unit timers with pin selected");

    property p_unit_rgn;
        @(posedge ref_clk) disable iff (!rst_b || !clk_en)
        !dclk_sel && rgn_ev[0] && !rate_gen1_out |=> unit_timer_tick;
    endproperty
    a_unit_rgn: assert property (p_unit_rgn)
        else $error("first generator edge gave no unit tick");

    property p_rgn_int;
        @(posedge ref_clk) disable iff (!rst_b || !clk_en)
        !ext5_sel && bcnt_r[0] == div_r[0]
            |=> baud_rate_gen_out[0] != $past(baud_rate_gen_out[0]);
    endproperty
    a_rgn_int: assert property (p_rgn_int)
        else $error("first generator ignored internal clock");

    c_unit: cover property (@(posedge ref_clk) unit_timer_tick);
endmodule // tcr_timers

// File: tcr_pkg.sv
// tcr_pkg: constants for the timer and clock routing block
// assumes a plain register port and a single system clock
package tcr_pkg;
    // register port geometry
    localparam int TCR_AW = 8;
    localparam int TCR_DW = 32;
    localparam int TCR_STRIDE = 4;
    // register byte addresses
    localparam logic [TCR_AW-1:0] TCR_MODE_BASE = 8'h00;
    localparam logic [TCR_AW-1:0] TCR_REF_BASE = 8'h10;
    localparam logic [TCR_AW-1:0] TCR_CNT_BASE = 8'h20;
    localparam logic [TCR_AW-1:0] TCR_ROUTE_ADDR = 8'h30;
    localparam logic [TCR_AW-1:0] TCR_BSEL_ADDR = 8'h34;
    localparam logic [TCR_AW-1:0] TCR_RGN_BASE = 8'h40;
    // timer mode fields
    localparam int TCR_F_SRC = 0;
    localparam int TCR_F_EDGE = 2;
    localparam int TCR_F_TOG = 4;
    localparam int TCR_F_GATE = 5;
    localparam int TCR_F_EN = 6;
    localparam int TCR_MODE_W = 7;
    // clock source codes
    localparam logic [1:0] TCR_SRC_CASC = 2'h0;
    localparam logic [1:0] TCR_SRC_SYS = 2'h1;
    localparam logic [1:0] TCR_SRC_DIV = 2'h2;
    localparam logic [1:0] TCR_SRC_PIN = 2'h3;
    // capture edge bits
    localparam int TCR_E_RISE = 0;
    localparam int TCR_E_FALL = 1;
    // routing fields
    localparam int TCR_F_EXT5 = 0;
    localparam int TCR_F_DCLK = 1;
    localparam int TCR_ROUTE_W = 2;
    localparam int TCR_BSEL_W = 5;
    // pin index of the fifth external clock
    localparam int TCR_EXT5_IX = 4;
    // prescaler
    localparam int TCR_DIV16 = 16;
    localparam int TCR_PRE_W = 4;
    // values after reset
    localparam logic [TCR_MODE_W-1:0] TCR_MODE_RST = 7'h00;
    localparam logic [15:0] TCR_REF_RST = 16'hffff;
    localparam logic [15:0] TCR_RGN_RST = 16'h0000;
    localparam logic [TCR_ROUTE_W-1:0] TCR_ROUTE_RST = 2'h0;
    localparam logic [TCR_DW-1:0] TCR_BSEL_RST = 32'h0000_0000;
endpackage

// File: tcr_pin_src.sv
// tcr_pin_src: model of the pins that face the timer block
// assumes the bench asks for levels; pins change after ref_clk edges
`timescale 1ns/1ps
module tcr_pin_src (
    // system clock
    input wire logic ref_clk,
    // requests from the bench
    input wire logic [3:0] pin_req,
    input wire logic [1:0] gate_req,
    input wire logic [9:0] clk_run,
    input wire logic tm_run,
    // pins towards the block
    output logic [3:0] timer_in_pin,
    output logic gate_in_a,
    output logic gate_in_b,
    output logic [9:0] ext_clock_in,
    output logic dedicated_timer_clock_pin
);
    localparam int EXT_HALF = 5; // half period of clock pins
    localparam int TM_HALF = 7; // half period of dedicated pin
    int ext_cnt; // phase of clock pins
    int tm_cnt; // phase of dedicated pin
    // all pins quiet at time zero
    initial begin
        timer_in_pin = 4'h0;
        gate_in_a = 1'b0;
        gate_in_b = 1'b0;
        ext_clock_in = 10'h000;
        dedicated_timer_clock_pin = 1'b0;
        ext_cnt = 0;
        tm_cnt = 0;
    end
    // timer and gate pins follow the bench one edge late
    always @(posedge ref_clk) begin
        timer_in_pin <= pin_req;
        gate_in_a <= gate_req[0];
        gate_in_b <= gate_req[1];
    end
    // clock pins run only when asked, else stand still
    always @(posedge ref_clk) begin
        ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
        tm_cnt <= (tm_cnt == TM_HALF - 1) ? 0 : tm_cnt + 1;
        if (ext_cnt == EXT_HALF - 1) begin
            ext_clock_in <= ext_clock_in ^ clk_run;
        end
        if (tm_cnt == TM_HALF - 1 && tm_run) begin
            dedicated_timer_clock_pin <= ~dedicated_timer_clock_pin;
        end
    end
endmodule // tcr_pin_src

// File: tcr_timers_tb_top.sv
// tcr_timers_tb_top: self-checking bench for the timer block
// assumes tcr_pkg and tcr_pin_src are compiled first
`timescale 1ns/1ps
module tcr_timers_tb_top;
    import tcr_pkg::*;
    logic ref_clk = 1'b0; // system clock
    logic rst_b = 1'b0; // reset, active low
    logic [7:0] reg_addr = 8'h00; // register port
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] pin_req = 4'h0; // model requests
    logic [1:0] gate_req = 2'h0;
    logic [9:0] clk_run = 10'h000;
    logic tm_run = 1'b0;
    logic [3:0] timer_in_pin, timer_out_pin; // pins
    logic gate_in_a, gate_in_b, dedicated_timer_clock_pin, unit_timer_tick;
    logic [9:0] ext_clock_in;
    logic [7:0] baud_rate_gen_out;
    logic [3:0] bank_clk_out;
    logic [7:0] w, w_q, rise; // watched outputs and their rises
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0; // cycles run so far
    int pc3 = 0; // pulses seen on timer 3
    always #5 ref_clk = ~ref_clk;
    tcr_pin_src src (.ref_clk(ref_clk), .pin_req(pin_req),
        .gate_req(gate_req), .clk_run(clk_run), .tm_run(tm_run),
        .timer_in_pin(timer_in_pin), .gate_in_a(gate_in_a),
        .gate_in_b(gate_in_b), .ext_clock_in(ext_clock_in),
        .dedicated_timer_clock_pin(dedicated_timer_clock_pin));
    tcr_timers dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_in_pin(timer_in_pin), .gate_in_a(gate_in_a),
        .gate_in_b(gate_in_b), .timer_out_pin(timer_out_pin),
        .ext_clock_in(ext_clock_in),
        .dedicated_timer_clock_pin(dedicated_timer_clock_pin),
        .baud_rate_gen_out(baud_rate_gen_out),
        .bank_clk_out(bank_clk_out), .unit_timer_tick(unit_timer_tick));
    // low timer outputs count as events, like the other rises
    assign w = {baud_rate_gen_out[7], bank_clk_out[0],
        baud_rate_gen_out[0], unit_timer_tick, ~timer_out_pin};
    assign rise = w & ~w_q;
    // edge history, pulse tally and hang guard
    always @(posedge ref_clk) begin
        w_q <= w;
        if (rise[3] === 1'b1) pc3 <= pc3 + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] at(input logic [7:0] b, input int i);
        at = b + 8'(TCR_STRIDE * i);
    endfunction
    // timer mode word with the enable bit set
    function automatic logic [31:0] md(input logic [1:0] s,
        input logic [1:0] e, input logic t, input logic g);
        md = 32'h0000_0000;
        md[TCR_F_SRC +: 2] = s;
        md[TCR_F_EDGE +: 2] = e;
        md[TCR_F_TOG] = t;
        md[TCR_F_GATE] = g;
        md[TCR_F_EN] = 1'b1;
    endfunction
    // one-cycle write, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // read data stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        v = reg_rdata;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // cycles between two rises of watched output k
    task automatic gap(input int k, input int e, input string nm);
        int n;
        n = 0;
        waitc(40);
        while (rise[k] !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rise[k] !== 1'b1 && n < 200);
        chk(nm, e, n);
    endtask
    // reset values, write-back and a hole in the map
    task automatic t_regs();
        logic [31:0] v;
        chk("out_idle", 32'h0000_000f, {28'h0, timer_out_pin});
        rd(at(TCR_MODE_BASE, 0), v); chk("mode0", 32'h0000_0000, v);
        rd(at(TCR_REF_BASE, 3), v); chk("ref3", 32'h0000_ffff, v);
        rd(TCR_ROUTE_ADDR, v); chk("route", 32'h0000_0000, v);
        rd(8'hfc, v); chk("hole", 32'h0000_0000, v);
        wr(at(TCR_REF_BASE, 1), 32'h1234_abcd);
        rd(at(TCR_REF_BASE, 1), v); chk("ref1", 32'h0000_abcd, v);
        wr(at(TCR_MODE_BASE, 1), md(TCR_SRC_DIV, 2'h3, 1'b1, 1'b1));
        rd(at(TCR_MODE_BASE, 1), v); chk("mode1", 32'h0000_007e, v);
        wr(at(TCR_MODE_BASE, 1), 32'h0000_0000);
    endtask
    // sysclk pulse, div16 toggle and a cascaded pair
    task automatic t_timers();
        wr(at(TCR_REF_BASE, 0), 32'h0000_0002);
        wr(at(TCR_MODE_BASE, 0), md(TCR_SRC_SYS, 2'h0, 1'b0, 1'b0));
        gap(0, 3, "pulse_gap");
        @(posedge ref_clk);
        chk("pulse_w", 32'h0000_0001, {31'h0, timer_out_pin[0]});
        wr(at(TCR_REF_BASE, 2), 32'h0000_0000);
        wr(at(TCR_MODE_BASE, 2), md(TCR_SRC_DIV, 2'h0, 1'b1, 1'b0));
        gap(2, 32, "tog_gap");
        // park timer 0 first: a count above the new ref would wrap 64k
        wr(at(TCR_MODE_BASE, 0), 32'h0000_0000);
        wr(at(TCR_REF_BASE, 0), 32'h0000_0001);
        wr(at(TCR_REF_BASE, 1), 32'h0000_0002);
        wr(at(TCR_MODE_BASE, 1), md(TCR_SRC_CASC, 2'h0, 1'b0, 1'b0));
        wr(at(TCR_MODE_BASE, 0), md(TCR_SRC_SYS, 2'h0, 1'b0, 1'b0));
        gap(1, 6, "casc_gap");
        wr(at(TCR_MODE_BASE, 0), 32'h0000_0000);
        wr(at(TCR_MODE_BASE, 1), 32'h0000_0000);
        wr(at(TCR_MODE_BASE, 2), 32'h0000_0000);
    endtask
    // timer 3 on its pin: rise only, then both edges
    task automatic t_pin();
        int p;
        wr(at(TCR_REF_BASE, 3), 32'h0000_0001);
        wr(at(TCR_MODE_BASE, 3), md(TCR_SRC_PIN, 2'h1, 1'b0, 1'b0));
        p = pc3;
        pin_req[3] <= 1'b1; waitc(12);
        pin_req[3] <= 1'b0; waitc(12);
        chk("rise_one", 32'h0000_0000, 32'(pc3 - p));
        pin_req[3] <= 1'b1; waitc(12);
        pin_req[3] <= 1'b0; waitc(12);
        chk("rise_two", 32'h0000_0001, 32'(pc3 - p));
        wr(at(TCR_MODE_BASE, 3), md(TCR_SRC_PIN, 2'h3, 1'b0, 1'b0));
        p = pc3;
        pin_req[3] <= 1'b1; waitc(12);
        pin_req[3] <= 1'b0; waitc(12);
        chk("both", 32'h0000_0001, 32'(pc3 - p));
        wr(at(TCR_MODE_BASE, 3), 32'h0000_0000);
    endtask
    // gate a freezes timer 0 but not timer 2; release restarts
    task automatic t_gate();
        logic [31:0] c1, c2, d1, d2;
        wr(at(TCR_REF_BASE, 0), 32'h0000_ffff);
        wr(at(TCR_REF_BASE, 2), 32'h0000_ffff);
        wr(at(TCR_MODE_BASE, 0), md(TCR_SRC_SYS, 2'h0, 1'b0, 1'b1));
        wr(at(TCR_MODE_BASE, 2), md(TCR_SRC_SYS, 2'h0, 1'b0, 1'b1));
        waitc(30);
        gate_req <= 2'h1;
        waitc(10);
        rd(at(TCR_CNT_BASE, 0), c1);
        rd(at(TCR_CNT_BASE, 2), d1);
        waitc(5);
        rd(at(TCR_CNT_BASE, 0), c2);
        rd(at(TCR_CNT_BASE, 2), d2);
        chk("frozen", c1, c2);
        chk("ran", 32'h0000_0001, {31'h0, c1 >= 32'd20});
        chk("other_runs", 32'h0000_0001, {31'h0, d1 !== d2});
        gate_req <= 2'h0;
        waitc(10);
        rd(at(TCR_CNT_BASE, 0), c1);
        chk("restart", 32'h0000_0001, {31'h0, c1 < 32'd16});
        wr(at(TCR_MODE_BASE, 0), 32'h0000_0000);
        wr(at(TCR_MODE_BASE, 2), 32'h0000_0000);
    endtask
    // generators, bank selector and the unit tick source
    task automatic t_route();
        wr(at(TCR_RGN_BASE, 0), 32'h0000_0001);
        wr(at(TCR_RGN_BASE, 7), 32'h0000_0002);
        gap(5, 4, "gen0");
        gap(7, 6, "gen7");
        gap(4, 4, "tick_int");
        wr(TCR_BSEL_ADDR, 32'h0000_000a);
        gap(6, 4, "bank_gen");
        clk_run <= 10'h018;
        wr(TCR_BSEL_ADDR, 32'h0000_0003);
        gap(6, 10, "bank_pin");
        wr(at(TCR_RGN_BASE, 0), 32'h0000_0000);
        wr(TCR_ROUTE_ADDR, 32'h0000_0001);
        gap(4, 20, "tick_ext5");
        tm_run <= 1'b1;
        wr(TCR_ROUTE_ADDR, 32'h0000_0003);
        gap(4, 14, "tick_ded");
    endtask
    // main sequence
    initial begin
        waitc(10);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_timers();
        t_pin();
        t_gate();
        t_route();
        report_and_stop();
    end
endmodule // tcr_timers_tb_top
